// ==== phy_autoneg_advert_register.sv ====
// per-port negotiation advertisement registers with strap capture and loader
// What this block does
// - loader rewrites both registers after reset release and on each reload command
// - bit 13 read/write, resets 0, advertises remote fault when set
// - bit 11 read/write, advertises asymmetric pause when set
// - bit 10 read/write, advertises symmetric pause when set
// - bit 8 read/write, resets 1, advertises 100 full duplex
// - bit 7 read/write, resets 1, advertises 100 half duplex
// - bit 6 read/write, advertises 10 full duplex, default from straps
// - bit 5 read/write, advertises 10 half duplex, default from straps
// - bits 4:0 read/write selector, resets to 00001
// - manual pause strap 0: symmetric 1, asymmetric follows full duplex pause strap
// - manual pause strap 1: both pause bits load as 0
// - 10 full duplex default is autoneg OR (not speed AND duplex)
// - 10 half duplex default is autoneg OR not speed
// - straps captured when reset is released and held afterwards
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module phy_autoneg_advert_register (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire adv_reg_pkg::strap_t [1:0]  strap_pins,
    input  wire adv_reg_pkg::wb_req_t       wb_req,
    output var  adv_reg_pkg::wb_rsp_t       wb_rsp,
    output var  logic [1:0][15:0]           negotiation_advert_reg,
    output var  logic                       loader_busy
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        adv_reg_pkg::strap_t [1:0] sync1;
        adv_reg_pkg::strap_t [1:0] sync2;
        adv_reg_pkg::strap_t [1:0] straps;
        logic                      boot;
        adv_reg_pkg::load_t        ld;
        logic                      busy;
        logic [1:0][15:0]          adv;
        adv_reg_pkg::wb_rsp_t      rsp;
    } state_t;

    localparam state_t RESET_STATE = '{
        sync1  : '0,
        sync2  : '0,
        straps : '0,
        boot   : 1'b1,
        ld     : adv_reg_pkg::LD_IDLE,
        busy   : 1'b0,
        adv    : {adv_reg_pkg::ADV_RESET, adv_reg_pkg::ADV_RESET},
        rsp    : '0
    };

    state_t           st;
    state_t           next_st;
    logic             req;
    logic             reload;
    logic [31:0]      rd;
    logic [15:0]      wmask;
    logic [1:0][15:0] dflt;

    // ************************************************************
    // per-port load values from the captured straps
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_port
            adv_reg_pkg::strap_t s;
            logic                sym;
            logic                asym;
            logic                fd10;
            logic                hd10;
            assign s    = st.straps[g];
            assign sym  = ~s.manual_pause_boot_setting;
            assign asym = ~s.manual_pause_boot_setting
                        & s.full_duplex_pause_boot_setting;
            assign fd10 = s.autoneg | (~s.speed & s.duplex);
            assign hd10 = s.autoneg | ~s.speed;
            // remote fault and bit 12 load as 0, 100 abilities as 1
            assign dflt[g] = {3'b000, 1'b0, asym, sym, 1'b0, 1'b1, 1'b1,
                              fd10, hd10, adv_reg_pkg::SELECTOR_8023};
        end
    endgenerate

    // ************************************************************
    // bus slave and loader
    // ************************************************************
    always_comb begin
        next_st = st;
        req     = wb_req.cyc & wb_req.stb & ~st.rsp.ack;
        reload  = 1'b0;
        rd      = 32'h0000_0000;
        // reserved read-only bits never take a write
        wmask   = adv_reg_pkg::ADV_RW_MASK
                & {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

        next_st.sync1 = strap_pins;
        next_st.sync2 = st.sync1;
        next_st.boot  = 1'b0;

        if (req) begin
            if (wb_req.adr == adv_reg_pkg::ADV_P1_OFFSET) begin
                rd = {16'h0000, st.adv[0]};
                if (wb_req.we) begin
                    next_st.adv[0] = (st.adv[0] & ~wmask)
                                   | (wb_req.dat[15:0] & wmask);
                end
            end else if (wb_req.adr == adv_reg_pkg::ADV_P2_OFFSET) begin
                rd = {16'h0000, st.adv[1]};
                if (wb_req.we) begin
                    next_st.adv[1] = (st.adv[1] & ~wmask)
                                   | (wb_req.dat[15:0] & wmask);
                end
            end else if (wb_req.adr == adv_reg_pkg::LOADER_CTRL_OFFSET) begin
                rd = 32'h0000_0000;
                if (wb_req.we && wb_req.sel[0]) begin
                    reload = wb_req.dat[adv_reg_pkg::RELOAD_BIT];
                end
            end else if (wb_req.adr == adv_reg_pkg::LOADER_STATUS_OFFSET) begin
                rd = {21'h00_0000, st.straps[1], st.straps[0], st.busy};
            end else begin
                // unmapped: acknowledged, reads zero, writes dropped
                rd = 32'h0000_0000;
            end
        end

        next_st.rsp.ack = req;
        next_st.rsp.dat = rd;

        // loader runs after the bus so a load wins over a same-cycle write
        case (st.ld)
            adv_reg_pkg::LD_IDLE: begin
                next_st.ld = adv_reg_pkg::LD_IDLE;
            end
            adv_reg_pkg::LD_PORT1: begin
                next_st.adv[0] = dflt[0];
                next_st.ld     = adv_reg_pkg::LD_PORT2;
            end
            adv_reg_pkg::LD_PORT2: begin
                next_st.adv[1] = dflt[1];
                next_st.ld     = adv_reg_pkg::LD_IDLE;
            end
            default: begin
                next_st.ld = adv_reg_pkg::LD_IDLE;
            end
        endcase

        // a reload in mid-load restarts from port 1
        if (reload) begin
            next_st.ld = adv_reg_pkg::LD_PORT1;
        end
        // first cycle after release: catch straps once, then load
        if (st.boot) begin
            next_st.straps = st.sync2;
            next_st.ld     = adv_reg_pkg::LD_PORT1;
        end
        next_st.busy = (next_st.ld != adv_reg_pkg::LD_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st       <= RESET_STATE;
            // synchronisers keep running so straps are settled at release
            st.sync1 <= next_st.sync1;
            st.sync2 <= next_st.sync2;
        end else begin
            st <= next_st;
        end
    end

    assign wb_rsp                 = st.rsp;
    assign negotiation_advert_reg = st.adv;
    assign loader_busy            = st.busy;

    // ************************************************************
    // checks
    // ************************************************************
    logic wr_p1;
    logic quiet;
    assign wr_p1 = req & wb_req.we & (wb_req.sel == 4'hF)
                 & (wb_req.adr == adv_reg_pkg::ADV_P1_OFFSET);
    assign quiet = (st.ld == adv_reg_pkg::LD_IDLE) & ~st.boot;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // the release edge itself still samples rst high, so it starts no attempt
    property p_boot_load;
        !rst && st.boot |=> st.ld == adv_reg_pkg::LD_PORT1 ##1 st.ld == adv_reg_pkg::LD_PORT2
                 ##1 st.ld == adv_reg_pkg::LD_IDLE && !st.busy;
    endproperty
    a_boot_load: assert property (p_boot_load)
        else $error("loader did not run after reset release");

    property p_reload;
        req && wb_req.we && wb_req.sel[0] && !st.boot
        && wb_req.adr == adv_reg_pkg::LOADER_CTRL_OFFSET
        && wb_req.dat[adv_reg_pkg::RELOAD_BIT]
        |=> st.busy [*2] ##1 st.adv[1] == dflt[1];
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload command did not rewrite registers");

    property p_remote_fault;
        wr_p1 && quiet
        |=> st.adv[0][adv_reg_pkg::REMOTE_FAULT_BIT] == $past(wb_req.dat[13]);
    endproperty
    a_remote_fault: assert property (p_remote_fault)
        else $error("remote fault bit did not take write");

    property p_pause_write;
        wr_p1 && quiet |=> st.adv[0][11:10] == $past(wb_req.dat[11:10]) && st.rsp.ack;
    endproperty
    a_pause_write: assert property (p_pause_write)
        else $error("pause bits did not take write");

    property p_hundred;
        st.ld == adv_reg_pkg::LD_PORT1
        |=> st.adv[0][adv_reg_pkg::FD100_BIT] && st.adv[0][adv_reg_pkg::HD100_BIT]
            && !st.adv[0][adv_reg_pkg::REMOTE_FAULT_BIT];
    endproperty
    a_hundred: assert property (p_hundred)
        else $error("100 abilities not loaded as 1");

    property p_fd10;
        st.ld == adv_reg_pkg::LD_PORT1
        |=> st.adv[0][adv_reg_pkg::FD10_BIT]
            == (st.straps[0].autoneg | (~st.straps[0].speed & st.straps[0].duplex));
    endproperty
    a_fd10: assert property (p_fd10)
        else $error("10 full duplex load value wrong");

    property p_hd10;
        st.ld == adv_reg_pkg::LD_PORT2
        |=> st.adv[1][adv_reg_pkg::HD10_BIT]
            == (st.straps[1].autoneg | ~st.straps[1].speed);
    endproperty
    a_hd10: assert property (p_hd10)
        else $error("10 half duplex load value wrong");

    property p_selector;
        st.ld == adv_reg_pkg::LD_PORT2
        |=> st.adv[1][adv_reg_pkg::SELECTOR_MSB:0] == adv_reg_pkg::SELECTOR_8023;
    endproperty
    a_selector: assert property (p_selector)
        else $error("selector not loaded as 802.3");

    property p_pause_load;
        st.ld == adv_reg_pkg::LD_PORT1
        |=> st.adv[0][adv_reg_pkg::SYM_PAUSE_BIT] == ~st.straps[0].manual_pause_boot_setting
         && st.adv[0][adv_reg_pkg::ASYM_PAUSE_BIT]
            == (~st.straps[0].manual_pause_boot_setting
                & st.straps[0].full_duplex_pause_boot_setting);
    endproperty
    a_pause_load: assert property (p_pause_load)
        else $error("pause load values wrong");

    property p_strap_hold;
        !st.boot |=> $stable(st.straps);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("captured straps changed");

    property p_strap_catch;
        !rst && st.boot |=> st.straps == $past(st.sync2);
    endproperty
    a_strap_catch: assert property (p_strap_catch)
        else $error("straps not caught at release");

    property p_reserved;
        st.adv[0][15:14] == 2'b00 && !st.adv[0][9]
        && st.adv[1][15:14] == 2'b00 && !st.adv[1][9];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");
endmodule : phy_autoneg_advert_register
`default_nettype wire

// ==== adv_reg_pkg.sv ====
// constants and types for the negotiation advertisement register bank
`default_nettype none
package adv_reg_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam int          ADR_W                = 8;
    localparam logic [7:0]  ADV_P1_OFFSET        = 8'h04;
    localparam logic [7:0]  ADV_P2_OFFSET        = 8'h44;
    localparam logic [7:0]  LOADER_CTRL_OFFSET   = 8'h80;
    localparam logic [7:0]  LOADER_STATUS_OFFSET = 8'h84;
    // ************************************************************
    // advertisement field layout
    // ************************************************************
    localparam logic [15:0] ADV_RW_MASK          = 16'h3DFF;
    localparam logic [15:0] ADV_RESET            = 16'h0181;
    localparam int          REMOTE_FAULT_BIT     = 13;
    localparam int          RSVD_RW_BIT          = 12;
    localparam int          ASYM_PAUSE_BIT       = 11;
    localparam int          SYM_PAUSE_BIT        = 10;
    localparam int          FD100_BIT            = 8;
    localparam int          HD100_BIT            = 7;
    localparam int          FD10_BIT             = 6;
    localparam int          HD10_BIT             = 5;
    localparam int          SELECTOR_MSB         = 4;
    localparam logic [4:0]  SELECTOR_8023        = 5'h01;
    localparam int          RELOAD_BIT           = 0;
    localparam int          BUSY_BIT             = 0;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {LD_IDLE, LD_PORT1, LD_PORT2} load_t;
    typedef struct packed {
        logic       duplex;
        logic       speed;
        logic       autoneg;
        logic       full_duplex_pause_boot_setting;
        logic       manual_pause_boot_setting;
    } strap_t;
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADR_W-1:0]  adr;
        logic [31:0]       dat;
    } wb_req_t;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;
endpackage : adv_reg_pkg
`default_nettype wire

// ==== wb_host_model.sv ====
// classic wishbone host model that drives the register bank
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
    input  wire logic                 clk,
    output var  adv_reg_pkg::wb_req_t req,
    input  wire adv_reg_pkg::wb_rsp_t rsp
);
    initial begin
        req = '0;
    end
    // ******************************
    // one classic cycle
    // ******************************
    // request held until ack is sampled high at a rising edge
    task automatic access(input logic we, input logic [7:0] adr,
                          input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wdat};
        do @(posedge clk); while (rsp.ack !== 1'b1);
        rdat = rsp.dat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        // stale data never looks valid once released
        req.dat <= ~wdat;
    endtask : access
endmodule : wb_host_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the advertisement register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                     clk;
    logic                     rst;
    adv_reg_pkg::strap_t [1:0] straps;
    adv_reg_pkg::wb_req_t     req;
    adv_reg_pkg::wb_rsp_t     rsp;
    logic [1:0][15:0]         adv;
    logic                     busy;
    logic [31:0]              rd;
    logic [4:0]               s1;
    logic [4:0]               s2;
    int                       errors;
    int                       compares;
    int                       cycles;
    phy_autoneg_advert_register u_phy_autoneg_advert_register (
        .clk(clk), .rst(rst), .strap_pins(straps), .wb_req(req), .wb_rsp(rsp),
        .negotiation_advert_reg(adv), .loader_busy(busy));
    wb_host_model u_wb_host_model (.clk(clk), .req(req), .rsp(rsp));
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        straps = '0;
    end
    always #12.5 clk = ~clk;
    // ******************************
    // helpers
    // ******************************
    // strap vector order: duplex, speed, autoneg, fd pause, manual pause
    function automatic logic [15:0] exp_word(input logic [4:0] s);
        logic [15:0] w;
        w = 16'h0181;
        w[11] = ~s[0] & s[1];
        w[10] = ~s[0];
        w[6] = s[2] | (~s[3] & s[4]);
        w[5] = s[2] | ~s[3];
        return w;
    endfunction : exp_word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic do_reset(input logic [4:0] a, input logic [4:0] b);
        @(posedge clk);
        rst <= 1'b1;
        straps <= {b, a};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // loader is done three edges after release
        repeat (2) @(posedge clk);
        chk(busy, 32'h1, "loader busy after release");
        repeat (2) @(posedge clk);
        chk(busy, 32'h0, "loader idle after release");
    endtask : do_reset
    task automatic final_report;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // ******************************
    // scenarios
    // ******************************
    // every speed strap combination, both manual pause settings
    task automatic t_strap_defaults;
        for (int i = 0; i < 8; i++) begin
            s1 = {i[2:0], i[1], 1'b0};
            s2 = {i[2:0], 1'b1, 1'b1};
            do_reset(s1, s2);
            u_wb_host_model.access(1'b0, 8'h04, 32'h0, rd);
            chk(rd, {16'h0, exp_word(s1)}, "port1 default");
            chk(adv[0], exp_word(s1), "port1 word");
            u_wb_host_model.access(1'b0, 8'h44, 32'h0, rd);
            chk(rd, {16'h0, exp_word(s2)}, "port2 default");
            chk(adv[1], exp_word(s2), "port2 word");
        end
    endtask : t_strap_defaults
    // bits 15:14 and 9 kept at zero on writes; bit 12 is written as zero
    task automatic t_fields;
        u_wb_host_model.access(1'b1, 8'h04, 32'hFFFF_EFFF, rd);
        u_wb_host_model.access(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h0000_2DFF, "rw and reserved bits");
        chk(adv[0], 16'h2DFF, "port1 word set");
        u_wb_host_model.access(1'b1, 8'h04, 32'h0, rd);
        u_wb_host_model.access(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h0, "all cleared");
        u_wb_host_model.access(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        u_wb_host_model.access(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0, "unmapped reads zero");
    endtask : t_fields
    // reload after straps moved: captured values must be reused
    task automatic t_reload;
        @(posedge clk);
        straps <= ~{s2, s1};
        u_wb_host_model.access(1'b1, 8'h80, 32'h1, rd);
        chk(busy, 32'h1, "loader busy on reload");
        repeat (3) @(posedge clk);
        u_wb_host_model.access(1'b0, 8'h04, 32'h0, rd);
        chk(rd, {16'h0, exp_word(s1)}, "port1 reloaded");
        u_wb_host_model.access(1'b0, 8'h44, 32'h0, rd);
        chk(rd, {16'h0, exp_word(s2)}, "port2 reloaded");
        u_wb_host_model.access(1'b0, 8'h84, 32'h0, rd);
        chk(rd, {21'h0, s2, s1, 1'b0}, "held straps");
    endtask : t_reload
    // ******************************
    // sequence and timeout
    // ******************************
    initial begin
        errors = 0;
        compares = 0;
        t_strap_defaults;
        t_fields;
        t_reload;
        final_report;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 5000) begin
                errors++;
                $display("MISMATCH t=%0t timeout", $time);
                final_report;
            end
        end
    end
endmodule : tb
`default_nettype wire
